// ===== rtl/ssio_pkg.sv
// ssio_pkg: constants and carrier types of the synchronous serial unit
// assumes a 40 MHz aclk and an AXI4-Lite register port
package ssio_pkg;
  localparam logic [4:0] A_CTL = 5'h00;
  localparam logic [4:0] A_TXD = 5'h04;
  localparam logic [4:0] A_RXD = 5'h08;
  localparam logic [4:0] A_STA = 5'h0C;
  localparam logic [4:0] A_IST = 5'h10;
  localparam logic [4:0] A_IMK = 5'h14;
  // control fields
  localparam int C_EN   = 0;
  localparam int C_UART = 1;
  localparam int C_LSB  = 2;
  localparam int C_EXT  = 3;
  localparam int C_RDY  = 4;
  localparam int C_CS   = 5;
  localparam int C_DIV  = 8;
  localparam logic [15:0] CTL_RST = 16'h2020;
  // interrupt bits
  localparam int I_TX = 0;
  localparam int I_RX = 1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BLK_BYTES = 4'h8;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  localparam longint CLK_HZ  = 40000000;
  localparam longint HEAD_US = 8000;
  localparam longint HEAD_CYC = (CLK_HZ * HEAD_US + 999999) / 1000000;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic sdo;
    logic rdy;
    logic cs_n;
  } ssio_pin_t;

  typedef struct packed {
    logic [15:0] ctl;
    logic [1:0]  mask;
    logic [1:0]  irq;
    logic [7:0]  sh;
    logic [7:0]  rx;
    logic [3:0]  bits;
    logic [3:0]  bytes;
    logic        blk_done;
    logic        busy;
    logic        sclk;
    logic        sdo;
    logic [7:0]  div;
    logic [19:0] gap;
    logic        aw_ok;
    logic        w_ok;
    logic [4:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [2:0]  ck_s;
    logic [1:0]  di_s;
    logic [1:0]  rd_s;
  } ssio_st_t;
endpackage : ssio_pkg

// ===== rtl/ssio_top.sv
// ssio_top: clock-synchronous serial unit with AXI4-Lite registers
// assumes partner pins are asynchronous to aclk; aclk is the main oscillator
// Operation
// - synchronous format only; setting the asynchronous (UART) bit just blocks transmit-byte writes, external-clock receive goes on; no start/stop format
// - writing the transmit byte starts a synchronous transfer at once
// - as clock master, each write also receives one byte
// - as clock master, transfer end sets transmit flag; received byte readable afterwards
// - shift clock is the main clock divided by a programmable ratio
// - least-significant-bit-first order selectable, bit 0 sent first
// - receiver drives ready; transmitter starts only after seeing it
// - after a long clock gap, next clock starts a new block
// - after eight bytes of a block, slave ignores further clocks
// - with external clock, receive flag set every eight clocks within a block, not once the block is done
`timescale 1ns/10ps
module ssio_top #(
  parameter int HEAD_CYC = int'(ssio_pkg::HEAD_CYC)
) (
  input  wire logic        aclk,          // main clock
  input  wire logic        aresetn,       // sync reset
  input  wire logic [31:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [31:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read valid
  input  wire logic        s_axi_rready,  // read ready
  input  wire logic        sclk_in,       // serial clock from partner
  output logic             sclk_out,      // serial clock driven
  output logic             sclk_oe,       // serial clock enable
  output logic             sdo,           // serial data out
  input  wire logic        sdi,           // serial data in
  output logic             receive_ready_out, // we can accept a byte
  input  wire logic        partner_ready, // partner can accept
  output logic             cs_n,          // chip select, low active
  output logic             irq            // level interrupt
);

  ssio_pkg::ssio_st_t st, nx;
  ssio_pkg::ssio_pin_t pin;
  logic wr_go, aw_hs, w_hs, ext_rise, ext_fall, tick, head;
  logic [4:0] raddr;

  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    out_bit = lsb ? s[0] : s[7];
  endfunction : out_bit

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic d,
                                          input logic lsb);
    shift_in = lsb ? {d, s[7:1]} : {s[6:0], d};
  endfunction : shift_in

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] be);
    merge = {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction : merge

  // half period in aclk cycles: the ratio field shifted right by one
  function automatic logic [7:0] half_div(input logic [15:0] c);
    half_div = {1'b0, c[ssio_pkg::C_DIV+1+:7]};
  endfunction : half_div

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign wr_go = st.aw_ok && st.w_ok && !st.bvalid;
  assign raddr = s_axi_araddr[4:0];
  assign s_axi_awready = !st.aw_ok && !st.bvalid;
  assign s_axi_wready  = !st.w_ok && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = st.rdata;

  // edge detect on second and third synchroniser stages only
  assign ext_rise = st.ck_s[1] && !st.ck_s[2];
  assign ext_fall = !st.ck_s[1] && st.ck_s[2];
  assign tick = st.div == 8'h00;
  assign head = 32'(st.gap) >= HEAD_CYC;

  always_comb begin
    nx = st;
    nx.ck_s = {st.ck_s[1:0], sclk_in};
    nx.di_s = {st.di_s[0], sdi};
    nx.rd_s = {st.rd_s[0], partner_ready};
    // set wins over software clear
    if (wr_go && st.waddr == ssio_pkg::A_IST && st.wstrb[0])
      nx.irq = st.irq & ~st.wdata[1:0];
    ////////////////////////////////////////////////////////////////////
    // register write
    if (aw_hs) begin
      nx.aw_ok = 1'b1;
      nx.waddr = s_axi_awaddr[4:0];
    end
    if (w_hs) begin
      nx.w_ok  = 1'b1;
      nx.wdata = s_axi_wdata;
      nx.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      nx.aw_ok  = 1'b0;
      nx.w_ok   = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp  = ssio_pkg::RESP_OK;
      case (st.waddr)
        ssio_pkg::A_CTL: nx.ctl = merge(st.ctl, st.wdata, st.wstrb);
        ssio_pkg::A_TXD: begin
          // a write while a byte is on the link is dropped
          if (st.wstrb[0] && st.ctl[ssio_pkg::C_EN] && !st.busy
              && !st.ctl[ssio_pkg::C_UART]) begin
            nx.sh   = st.wdata[7:0];
            nx.busy = 1'b1;
            nx.bits = 4'h0;
            nx.sdo  = out_bit(st.wdata[7:0], st.ctl[ssio_pkg::C_LSB]);
            nx.div  = half_div(st.ctl);
          end
        end
        ssio_pkg::A_IST: ;
        ssio_pkg::A_IMK: if (st.wstrb[0]) nx.mask = st.wdata[1:0];
        default: nx.bresp = ssio_pkg::RESP_ERR;
      endcase
    end
    if (st.bvalid && s_axi_bready) nx.bvalid = 1'b0;
    ////////////////////////////////////////////////////////////////////
    // register read
    if (s_axi_arvalid && s_axi_arready) begin
      nx.rvalid = 1'b1;
      nx.rresp  = ssio_pkg::RESP_OK;
      nx.rdata  = 32'h0;
      case (raddr)
        ssio_pkg::A_CTL: nx.rdata[15:0] = st.ctl;
        ssio_pkg::A_TXD: nx.rdata[7:0] = st.sh;
        ssio_pkg::A_RXD: nx.rdata[7:0] = st.rx;
        ssio_pkg::A_STA: nx.rdata[9:0] = {st.bytes, st.bits, st.blk_done, st.busy};
        ssio_pkg::A_IST: nx.rdata[1:0] = st.irq;
        ssio_pkg::A_IMK: nx.rdata[1:0] = st.mask;
        default: nx.rresp = ssio_pkg::RESP_ERR;
      endcase
    end
    if (st.rvalid && s_axi_rready) nx.rvalid = 1'b0;
    ////////////////////////////////////////////////////////////////////
    // master engine
    if (!st.ctl[ssio_pkg::C_EXT]) begin
      nx.sclk = st.busy ? st.sclk : 1'b1;
      if (st.busy) begin
        if (tick) nx.div = half_div(st.ctl) - 8'h01;
        else      nx.div = st.div - 8'h01;
        // hold off until the partner shows ready
        if (tick && (st.rd_s[1] || !st.ctl[ssio_pkg::C_RDY])) begin
          if (st.sclk) begin
            nx.sclk = 1'b0;
            if (st.bits != 4'h0)
              nx.sdo = out_bit(st.sh, st.ctl[ssio_pkg::C_LSB]);
          end else begin
            nx.sclk = 1'b1;
            nx.sh   = shift_in(st.sh, st.di_s[1], st.ctl[ssio_pkg::C_LSB]);
            nx.bits = st.bits + 4'h1;
            if (st.bits + 4'h1 == ssio_pkg::BYTE_BITS) begin
              nx.busy = 1'b0;
              nx.rx   = shift_in(st.sh, st.di_s[1], st.ctl[ssio_pkg::C_LSB]);
              nx.irq[ssio_pkg::I_TX] = 1'b1;
            end
          end
        end
      end
    end else begin
      ////////////////////////////////////////////////////////////////////
      // slave engine on the partner's clock
      nx.sclk = 1'b1;
      // gap runs rise to rise, so the first rise after idle still sees it
      if (ext_rise) nx.gap = 20'h0;
      else if (!head) nx.gap = st.gap + 20'h1;
      if (ext_rise && head) begin
        nx.bytes    = 4'h0;
        nx.blk_done = 1'b0;
      end
      if (ext_rise && (head || !st.blk_done)) begin
        nx.sh   = shift_in(st.sh, st.di_s[1], st.ctl[ssio_pkg::C_LSB]);
        nx.bits = (head ? 4'h0 : st.bits) + 4'h1;
        if ((head ? 4'h0 : st.bits) + 4'h1 == ssio_pkg::BYTE_BITS) begin
          nx.bits  = 4'h0;
          nx.busy  = 1'b0;
          nx.rx    = shift_in(st.sh, st.di_s[1], st.ctl[ssio_pkg::C_LSB]);
          nx.irq[ssio_pkg::I_RX] = 1'b1;
          nx.bytes = (head ? 4'h0 : st.bytes) + 4'h1;
          if ((head ? 4'h0 : st.bytes) + 4'h1 == ssio_pkg::BLK_BYTES)
            nx.blk_done = 1'b1;
        end
      end
      if (ext_fall && !st.blk_done && st.bits != 4'h0)
        nx.sdo = out_bit(st.sh, st.ctl[ssio_pkg::C_LSB]);
    end
    if (!st.ctl[ssio_pkg::C_EN]) begin
      nx.busy = 1'b0;
      nx.sclk = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st      <= '0;
      st.ctl  <= ssio_pkg::CTL_RST;
      st.sclk <= 1'b1;
      st.sdo  <= 1'b1;
      st.ck_s <= 3'h7;
    end else begin
      st <= nx;
    end
  end

  always_comb begin
    pin.sclk_o  = st.sclk;
    pin.sclk_oe = st.ctl[ssio_pkg::C_EN] && !st.ctl[ssio_pkg::C_EXT];
    pin.sdo     = st.sdo;
    pin.rdy     = st.ctl[ssio_pkg::C_EXT] && st.ctl[ssio_pkg::C_RDY]
                  && st.busy && st.bits == 4'h0;
    pin.cs_n    = st.ctl[ssio_pkg::C_CS];
  end

  assign sclk_out          = pin.sclk_o;
  assign sclk_oe           = pin.sclk_oe;
  assign sdo               = pin.sdo;
  assign receive_ready_out = pin.rdy;
  assign cs_n              = pin.cs_n;
  assign irq               = |(st.irq & st.mask);

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_start;
    @(posedge aclk) disable iff (!aresetn)
    wr_go && st.waddr == ssio_pkg::A_TXD && st.wstrb[0] && !st.busy
      && st.ctl[ssio_pkg::C_EN] && !st.ctl[ssio_pkg::C_UART] |=> st.busy;
  endproperty
  a_start: assert property (p_start) else $error("write did not start");

  property p_done;
    @(posedge aclk) disable iff (!aresetn)
    $rose(st.irq[ssio_pkg::I_TX]) |-> $past(st.busy) && !st.busy;
  endproperty
  a_done: assert property (p_done) else $error("tx flag without end");

  property p_bits;
    @(posedge aclk) disable iff (!aresetn)
    st.bits <= ssio_pkg::BYTE_BITS;
  endproperty
  a_bits: assert property (p_bits) else $error("bit count overrun");

  property p_sdo;
    @(posedge aclk) disable iff (!aresetn)
    $past(st.busy) && st.busy && !st.ctl[ssio_pkg::C_EXT] && $changed(st.sdo)
      |-> $fell(st.sclk);
  endproperty
  a_sdo: assert property (p_sdo) else $error("data moved off falling edge");

  property p_wait;
    @(posedge aclk) disable iff (!aresetn)
    st.busy && !st.ctl[ssio_pkg::C_EXT] && st.ctl[ssio_pkg::C_RDY]
      && $fell(st.sclk) |-> $past(st.rd_s[1]);
  endproperty
  a_wait: assert property (p_wait) else $error("clocked without ready");

  property p_lsb;
    @(posedge aclk) disable iff (!aresetn)
    $rose(st.busy) && st.ctl[ssio_pkg::C_LSB] && !st.ctl[ssio_pkg::C_EXT]
      |-> st.sdo == st.sh[0];
  endproperty
  a_lsb: assert property (p_lsb) else $error("first bit not bit 0");

  property p_blk;
    @(posedge aclk) disable iff (!aresetn)
    st.blk_done |-> st.bytes == ssio_pkg::BLK_BYTES;
  endproperty
  a_blk: assert property (p_blk) else $error("block end miscounted");

  property p_head;
    @(posedge aclk) disable iff (!aresetn)
    st.ctl[ssio_pkg::C_EXT] && ext_rise && head |=> st.bits == 4'h1 && !st.blk_done;
  endproperty
  a_head: assert property (p_head) else $error("heading not realigned");

  property p_rx8;
    @(posedge aclk) disable iff (!aresetn)
    st.ctl[ssio_pkg::C_EXT] && $rose(st.irq[ssio_pkg::I_RX]) |-> st.bits == 4'h0;
  endproperty
  a_rx8: assert property (p_rx8) else $error("rx flag off byte edge");

  property p_div;
    @(posedge aclk) disable iff (!aresetn)
    $past(st.busy) && $past(tick) && !$past(st.ctl[ssio_pkg::C_EXT]) && st.busy
      |-> st.div == $past(half_div(st.ctl)) - 8'h01;
  endproperty
  a_div: assert property (p_div) else $error("divider reload wrong");

endmodule : ssio_top

// ===== tb/ssio_peer.sv
// ssio_peer: far-end serial port, shifts msb first
// assumes an idle-high clock, driven by the device while sclk_oe is high
`timescale 1ns/10ps
module ssio_peer (
  input  wire logic aclk,     // bench clock
  input  wire logic sclk_dev, // clock from device
  input  wire logic sclk_oe,  // device drives clock
  input  wire logic sdo,      // data from device
  input  wire logic cs_n,     // select, low active
  output logic      sdi,      // data to device
  output logic      sclk_in   // clock to device
);
  logic [7:0] txs = 8'h00;
  logic [7:0] rxs = 8'h00;
  int         nrise = 0;
  wire        sck = sclk_oe ? sclk_dev : sclk_in;
  initial sclk_in = 1'b1;
  initial sdi = 1'b1;
  always @(negedge sck) begin
    sdi <= txs[7];
    txs <= {txs[6:0], 1'b0};
  end
  always @(posedge sck) begin
    rxs <= {rxs[6:0], sdo};
    nrise <= nrise + 1;
  end
  // deselected: line shows no stale value
  always @(posedge aclk) if (cs_n && sclk_oe) sdi <= ~sdi;
  task automatic load(input logic [7:0] b);
    txs = b;
    nrise = 0;
  endtask : load
  // clock stands high outside frames
  task automatic clocks(input int n);
    repeat (n) begin
      repeat (8) @(posedge aclk);
      sclk_in <= 1'b0;
      repeat (8) @(posedge aclk);
      sclk_in <= 1'b1;
    end
  endtask : clocks
endmodule : ssio_peer

// ===== tb/testbench.sv
// testbench: drives the serial unit over AXI4-Lite against ssio_peer
// assumes ssio_pkg register map and a 40 MHz aclk
`timescale 1ns/10ps
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        sclk_in, sclk_out, sclk_oe, sdo, sdi, receive_ready_out;
  logic        partner_ready, cs_n, irq, lsb;
  logic [7:0]  tx, px;
  int          fails = 0, total_checks = 0, cyc = 0, n;
  always #12.5 aclk = ~aclk;
  ssio_top #(.HEAD_CYC(200)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclk_in, .sclk_out,
    .sclk_oe, .sdo, .sdi, .receive_ready_out, .partner_ready, .cs_n, .irq);
  ssio_peer peer (.aclk, .sclk_dev(sclk_out), .sclk_oe, .sdo, .cs_n, .sdi, .sclk_in);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= {27'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wait_idle();
    repeat (200) begin
      rd(ssio_pkg::A_STA);
      if (d[0] === 1'b0) break;
    end
  endtask : wait_idle
  // f: rdy, ext, lsb, uart, en
  function automatic logic [31:0] cfg(input logic [7:0] dv, input logic [4:0] f);
    return {16'h0, dv, 3'h0, f};
  endfunction : cfg
  function automatic logic [31:0] ord(input logic [7:0] b, input logic l);
    logic [31:0] o;
    o = 32'h0;
    for (int i = 0; i < 8; i++) o[i] = l ? b[7 - i] : b[i];
    return o;
  endfunction : ord
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    partner_ready = 1'b1;
    void'($urandom(12));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ssio_pkg::A_CTL);
    chk(d, {16'h0, ssio_pkg::CTL_RST});
    chk({28'h0, cs_n, sclk_oe, sdo, irq}, 32'hA);
    rd(5'h18);
    chk(32'(r), 32'(ssio_pkg::RESP_ERR));
    wr(5'h1C, 32'h0);
    chk(32'(r), 32'(ssio_pkg::RESP_ERR));
    wr(ssio_pkg::A_CTL, cfg(8'h08, 5'h03));
    wr(ssio_pkg::A_TXD, 32'h5A);
    rd(ssio_pkg::A_STA);
    chk(32'(d[0]), 32'h0);
    // divide by 32: one fall-to-fall period
    wr(ssio_pkg::A_CTL, cfg(8'h20, 5'h01));
    wr(ssio_pkg::A_TXD, 32'hA5);
    n = 0;
    repeat (500) begin
      @(posedge aclk);
      if (sclk_out === 1'b0) break;
    end
    repeat (500) begin
      @(posedge aclk);
      n++;
      if (sclk_out === 1'b1) break;
    end
    repeat (500) begin
      @(posedge aclk);
      n++;
      if (sclk_out === 1'b0) break;
    end
    chk(32'(n), 32'd32);
    wait_idle();
    wr(ssio_pkg::A_IST, 32'h3);
    partner_ready <= 1'b0;
    wr(ssio_pkg::A_CTL, cfg(8'h08, 5'h11));
    wr(ssio_pkg::A_TXD, 32'hC3);
    repeat (60) @(posedge aclk);
    chk(32'(sclk_out), 32'h1);
    rd(ssio_pkg::A_STA);
    chk(32'(d[0]), 32'h1);
    partner_ready <= 1'b1;
    wait_idle();
    rd(ssio_pkg::A_IST);
    chk(32'(d[0]), 32'h1);
    wr(ssio_pkg::A_IST, 32'h3);
    for (int i = 0; i < 6; i++) begin
      lsb = i[0];
      tx = (i == 0) ? 8'h01 : 8'($urandom);
      px = (i == 1) ? 8'h80 : 8'($urandom);
      wr(ssio_pkg::A_CTL, cfg(8'h08, {2'h0, lsb, 2'h1}));
      chk(32'(cs_n), 32'h0);
      peer.load(px);
      wr(ssio_pkg::A_TXD, {24'h0, tx});
      wait_idle();
      rd(ssio_pkg::A_RXD);
      chk(d, ord(px, lsb));
      chk({24'h0, peer.rxs}, ord(tx, lsb));
      chk(32'(peer.nrise), 32'd8);
      rd(ssio_pkg::A_IST);
      chk(32'(d[0]), 32'h1);
      if (i == 0) begin
        chk(32'(irq), 32'h0);
        wr(ssio_pkg::A_IMK, 32'h3);
        @(posedge aclk);
        chk(32'(irq), 32'h1);
      end
      wr(ssio_pkg::A_IST, 32'h3);
      @(posedge aclk);
      chk(32'(irq), 32'h0);
    end
    // slave: noise bits, heading gap, one block, ignored byte, new block
    wr(ssio_pkg::A_CTL, cfg(8'h08, 5'h19));
    wr(ssio_pkg::A_TXD, 32'h3C);
    repeat (2) @(posedge aclk);
    chk(32'(receive_ready_out), 32'h1);
    repeat (300) @(posedge aclk);
    peer.clocks(3);
    repeat (10) @(posedge aclk);
    rd(ssio_pkg::A_IST);
    chk(32'(d[1]), 32'h0);
    repeat (300) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      if (i == 9) repeat (300) @(posedge aclk);
      tx = 8'($urandom);
      peer.load(tx);
      peer.clocks(8);
      repeat (10) @(posedge aclk);
      rd(ssio_pkg::A_IST);
      chk(32'(d[1]), 32'(i != 8));
      rd(ssio_pkg::A_RXD);
      if (i != 8) chk(d, {24'h0, tx});
      wr(ssio_pkg::A_IST, 32'h3);
    end
    summarize();
  end
endmodule : testbench
